// File: src/compact_tm_pkg.sv
`default_nettype none
package compact_tm_pkg;

  // ==========================================================
  // Widths and counter constants
  localparam int unsigned ADDR_W         = 8;
  localparam logic [9:0]  COUNT_ZERO     = 10'h000;
  localparam logic [9:0]  COUNT_ONE      = 10'h001;
  localparam logic [9:0]  COUNT_MAX      = 10'h3ff;
  localparam logic [2:0]  CMP_P_ZERO     = 3'h0;
  localparam logic [6:0]  P_LOW_ZERO     = 7'h00;
  localparam logic [10:0] PERIOD_FULL    = 11'h400;

  // ==========================================================
  // Register offsets (byte addresses) and fields
  localparam logic [ADDR_W-1:0] OFS_TIMER_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MODE_CTRL  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COMPARE_A  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COUNT      = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_FLAGS      = 8'h10;
  localparam int unsigned COUNTER_ON_BIT  = 3;
  localparam int unsigned FLAG_A_BIT      = 0;
  localparam int unsigned FLAG_P_BIT      = 1;
  localparam logic [7:0]  TIMER_CTRL_MASK = 8'h0f;
  localparam logic [7:0]  TIMER_CTRL_RST  = 8'h00;
  localparam logic [7:0]  MODE_CTRL_RST   = 8'h00;
  localparam logic [9:0]  COMPARE_A_RST   = 10'h000;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ==========================================================
  // Modes and pin function codes
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'h0,
    MODE_UNDEF   = 2'h1,
    MODE_PWM     = 2'h2,
    MODE_TIMER   = 2'h3
  } op_mode_t;

  localparam logic [1:0] CMP_LOW      = 2'h1;
  localparam logic [1:0] CMP_HIGH     = 2'h2;
  localparam logic [1:0] CMP_TOGGLE   = 2'h3;
  localparam logic [1:0] PWM_INACTIVE = 2'h0;
  localparam logic [1:0] PWM_ACTIVE   = 2'h1;
  localparam logic [1:0] PWM_WAVE     = 2'h2;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic op_mode_sel_hi;
    logic op_mode_sel_lo;
    logic pin_func_sel_hi;
    logic pin_func_sel_lo;
    logic pin_initial_level;
    logic pin_invert;
    logic pwm_role_swap;
    logic clear_source_sel;
  } timer_mode_control_t;

  typedef struct packed {
    logic [9:0] count;
    logic       match_a;
    logic       match_p;
    logic       on_rise;
  } count_status_t;

  function automatic op_mode_t mode_of(input timer_mode_control_t c);
    return op_mode_t'({c.op_mode_sel_hi, c.op_mode_sel_lo});
  endfunction : mode_of

endpackage : compact_tm_pkg
`default_nettype wire

// File: src/tm_count_core.sv
`default_nettype none
module tm_count_core
  import compact_tm_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                ce,
  input  wire logic                counter_on,
  input  wire timer_mode_control_t cfg,
  input  wire logic [9:0]          compare_a_value,
  input  wire logic [2:0]          compare_p_value,
  output var  count_status_t       status
);

  // ==========================================================
  // Counter state
  logic [9:0] count;
  logic [9:0] next_count;
  logic       on_prev;
  logic       next_on_prev;
  logic       running;
  logic       hit_a;
  logic       hit_p;
  logic       clear_on_a;

  // Comparators and clear selection; the stale count in the
  // rise cycle is kept out of the comparators by on_prev
  always_comb begin
    running = counter_on && on_prev && (mode_of(cfg) != MODE_UNDEF);
    hit_a = running && (compare_a_value != COUNT_ZERO)
            && (count == compare_a_value);
    hit_p = running && (compare_p_value != CMP_P_ZERO)
            && (count == {compare_p_value, P_LOW_ZERO});
    clear_on_a = (mode_of(cfg) == MODE_PWM) ? cfg.pwm_role_swap
                                            : cfg.clear_source_sel;
    next_on_prev = counter_on;
    next_count = count;
    if (counter_on && !on_prev) begin
      next_count = COUNT_ZERO;
    end else if (running) begin
      if (clear_on_a ? hit_a : hit_p) begin
        next_count = COUNT_ZERO;
      end else begin
        next_count = count + COUNT_ONE;
      end
    end
    status = '{count: count, match_a: hit_a, match_p: hit_p,
               on_rise: counter_on && !on_prev};
  end

  // Register stage, frozen while ce is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count   <= COUNT_ZERO;
      on_prev <= 1'h0;
    end else if (ce) begin
      count   <= next_count;
      on_prev <= next_on_prev;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_rise_clears;
    ce && counter_on && !on_prev |=> count == COUNT_ZERO;
  endproperty
  a_rise_clears: assert property (p_rise_clears)
    else $error("counter not cleared on enable rise");

  property p_off_holds;
    ce && !counter_on |=> count == $past(count);
  endproperty
  a_off_holds: assert property (p_off_holds)
    else $error("counter moved while off");

  property p_wrap;
    ce && running && count == COUNT_MAX && !(clear_on_a ? hit_a : hit_p)
      |=> count == COUNT_ZERO;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not wrap at maximum");

endmodule : tm_count_core
`default_nettype wire

// File: src/compact_timer_mode_control.sv
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`default_nettype none
module compact_timer_mode_control
  import compact_tm_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   timer_out_pin0,
  output logic                   timer_out_pin1,
  output logic                   timer_out_oe
);

  // ==========================================================
  // State
  logic [7:0]          timer_ctrl, next_timer_ctrl;
  timer_mode_control_t mode_ctrl, next_mode_ctrl;
  logic [9:0]          compare_a_value, next_compare_a_value;
  logic                flag_a, next_flag_a;
  logic                flag_p, next_flag_p;
  logic                aw_held, next_aw_held;
  logic                w_held, next_w_held;
  logic [ADDR_W-1:0]   wr_addr, next_wr_addr;
  logic [31:0]         wr_data, next_wr_data;
  logic [3:0]          wr_strb, next_wr_strb;
  logic                next_awready, next_wready, next_arready;
  logic                next_bvalid, next_rvalid;
  logic [1:0]          next_bresp, next_rresp;
  logic [31:0]         next_rdata;
  logic                pin_level, next_pin_level;
  logic                next_pin0, next_oe;
  logic                set_p;
  logic                wave_active;
  logic [10:0]         p_span, a_span, period, duty;
  op_mode_t            mode;
  logic [1:0]          pin_func;
  logic                counter_on;
  logic [2:0]          compare_p_value;
  count_status_t       status;

  assign counter_on      = timer_ctrl[COUNTER_ON_BIT];
  assign compare_p_value = timer_ctrl[2:0];
  assign mode            = mode_of(mode_ctrl);
  assign pin_func = {mode_ctrl.pin_func_sel_hi, mode_ctrl.pin_func_sel_lo};

  // ==========================================================
  // Helpers
  function automatic logic [7:0] merge_byte(input logic [7:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb,
                                            input int lane);
    return strb[lane] ? data[lane*8 +: 8] : old;
  endfunction : merge_byte

  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    return (a == OFS_TIMER_CTRL) || (a == OFS_MODE_CTRL) ||
           (a == OFS_COMPARE_A) || (a == OFS_COUNT) || (a == OFS_FLAGS);
  endfunction : addr_known

  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a);
    logic [31:0] v;
    v = '0;
    case (a)
      OFS_TIMER_CTRL: v[7:0] = timer_ctrl;
      OFS_MODE_CTRL:  v[7:0] = mode_ctrl;
      OFS_COMPARE_A:  v[9:0] = compare_a_value;
      OFS_COUNT:      v[9:0] = status.count;
      OFS_FLAGS: begin
        v[FLAG_A_BIT] = flag_a;
        v[FLAG_P_BIT] = flag_p;
      end
      default:        v = '0;
    endcase
    return v;
  endfunction : read_word

  // ==========================================================
  // Counter and comparators
  tm_count_core u_core (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .ce              (ce),
    .counter_on      (counter_on),
    .cfg             (mode_ctrl),
    .compare_a_value (compare_a_value),
    .compare_p_value (compare_p_value),
    .status          (status)
  );

  // ==========================================================
  // Bus slave, registers and match flags
  // Address and data are caught separately so either may come first
  always_comb begin
    next_timer_ctrl      = timer_ctrl;
    next_mode_ctrl       = mode_ctrl;
    next_compare_a_value = compare_a_value;
    next_flag_a          = flag_a;
    next_flag_p          = flag_p;
    next_aw_held         = aw_held;
    next_w_held          = w_held;
    next_wr_addr         = wr_addr;
    next_wr_data         = wr_data;
    next_wr_strb         = wr_strb;
    next_bvalid          = bvalid;
    next_bresp           = bresp;
    next_rvalid          = rvalid;
    next_rresp           = rresp;
    next_rdata           = rdata;
    if (awvalid && awready) begin
      next_aw_held = 1'h1;
      next_wr_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held  = 1'h1;
      next_wr_data = wdata;
      next_wr_strb = wstrb;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'h0;
    end
    if (aw_held && w_held && !bvalid) begin
      next_aw_held = 1'h0;
      next_w_held  = 1'h0;
      next_bvalid  = 1'h1;
      next_bresp   = addr_known(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      case (wr_addr)
        OFS_TIMER_CTRL: next_timer_ctrl =
          merge_byte(timer_ctrl, wr_data, wr_strb, 0) & TIMER_CTRL_MASK;
        OFS_MODE_CTRL: next_mode_ctrl = timer_mode_control_t'(
          merge_byte(mode_ctrl, wr_data, wr_strb, 0));
        OFS_COMPARE_A: begin
          next_compare_a_value[7:0] =
            merge_byte(compare_a_value[7:0], wr_data, wr_strb, 0);
          next_compare_a_value[9:8] = wr_strb[1] ? wr_data[9:8]
                                                 : compare_a_value[9:8];
        end
        OFS_FLAGS: if (wr_strb[0]) begin
          // Write one to clear
          next_flag_a = flag_a & ~wr_data[FLAG_A_BIT];
          next_flag_p = flag_p & ~wr_data[FLAG_P_BIT];
        end
        default: ;
      endcase
    end
    // Hardware set beats a same-cycle software clear
    set_p = status.match_p &&
            ((mode == MODE_PWM) || !mode_ctrl.clear_source_sel);
    next_flag_a = next_flag_a | status.match_a;
    next_flag_p = next_flag_p | set_p;
    if (rvalid && rready) begin
      next_rvalid = 1'h0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'h1;
      next_rdata  = read_word(araddr);
      next_rresp  = addr_known(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_ctrl      <= TIMER_CTRL_RST;
      mode_ctrl       <= timer_mode_control_t'(MODE_CTRL_RST);
      compare_a_value <= COMPARE_A_RST;
      flag_a          <= 1'h0;
      flag_p          <= 1'h0;
      aw_held         <= 1'h0;
      w_held          <= 1'h0;
      wr_addr         <= '0;
      wr_data         <= '0;
      wr_strb         <= '0;
      awready         <= 1'h0;
      wready          <= 1'h0;
      arready         <= 1'h0;
      bvalid          <= 1'h0;
      bresp           <= RESP_OKAY;
      rvalid          <= 1'h0;
      rresp           <= RESP_OKAY;
      rdata           <= '0;
    end else if (ce) begin
      timer_ctrl      <= next_timer_ctrl;
      mode_ctrl       <= next_mode_ctrl;
      compare_a_value <= next_compare_a_value;
      flag_a          <= next_flag_a;
      flag_p          <= next_flag_p;
      aw_held         <= next_aw_held;
      w_held          <= next_w_held;
      wr_addr         <= next_wr_addr;
      wr_data         <= next_wr_data;
      wr_strb         <= next_wr_strb;
      awready         <= next_awready;
      wready          <= next_wready;
      arready         <= next_arready;
      bvalid          <= next_bvalid;
      bresp           <= next_bresp;
      rvalid          <= next_rvalid;
      rresp           <= next_rresp;
      rdata           <= next_rdata;
    end
  end

  // ==========================================================
  // Output pin control
  // Spans are 11 bits so that a zero setting can mean 1024
  always_comb begin
    p_span = (compare_p_value == CMP_P_ZERO) ? PERIOD_FULL
             : {1'h0, compare_p_value, P_LOW_ZERO};
    a_span = (compare_a_value == COUNT_ZERO) ? PERIOD_FULL
             : {1'h0, compare_a_value};
    period = mode_ctrl.pwm_role_swap ? a_span : p_span;
    duty   = mode_ctrl.pwm_role_swap ? p_span
                                     : {1'h0, compare_a_value};
    wave_active = (duty >= period) || ({1'h0, status.count} < duty);
    next_pin_level = pin_level;
    next_oe        = 1'h0;
    case (mode)
      MODE_COMPARE: begin
        next_oe = 1'h1;
        if (status.on_rise) begin
          next_pin_level = mode_ctrl.pin_initial_level;
        end else if (status.match_a) begin
          case (pin_func)
            CMP_LOW:    next_pin_level = 1'h0;
            CMP_HIGH:   next_pin_level = 1'h1;
            CMP_TOGGLE: next_pin_level = ~pin_level;
            default:    next_pin_level = pin_level;
          endcase
        end
      end
      MODE_PWM: begin
        next_oe = 1'h1;
        case (pin_func)
          PWM_ACTIVE: next_pin_level = mode_ctrl.pin_initial_level;
          PWM_WAVE:   next_pin_level = wave_active
                        ? mode_ctrl.pin_initial_level
                        : ~mode_ctrl.pin_initial_level;
          default:    next_pin_level = ~mode_ctrl.pin_initial_level;
        endcase
      end
      default: next_oe = 1'h0;
    endcase
    next_pin0 = next_pin_level ^ mode_ctrl.pin_invert;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_level      <= 1'h0;
      timer_out_pin0 <= 1'h0;
      timer_out_pin1 <= 1'h1;
      timer_out_oe   <= 1'h0;
    end else if (ce) begin
      pin_level      <= next_pin_level;
      timer_out_pin0 <= next_pin0;
      timer_out_pin1 <= ~next_pin0;
      timer_out_oe   <= next_oe;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_timer_undriven;
    ce && (mode == MODE_TIMER) |=> !timer_out_oe;
  endproperty
  a_timer_undriven: assert property (p_timer_undriven)
    else $error("pin driven in timer mode");

  property p_flag_a;
    ce && status.match_a |=> flag_a;
  endproperty
  a_flag_a: assert property (p_flag_a)
    else $error("A flag not set on match");

  property p_no_p_flag;
    ce && (mode != MODE_PWM) && mode_ctrl.clear_source_sel && !flag_p
      |=> !flag_p;
  endproperty
  a_no_p_flag: assert property (p_no_p_flag)
    else $error("P flag raised with A clear source");

  property p_p_flag;
    ce && status.match_p && !mode_ctrl.clear_source_sel |=> flag_p;
  endproperty
  a_p_flag: assert property (p_p_flag)
    else $error("P flag missing with P clear source");

  property p_clear_src;
    ce && (mode != MODE_PWM) &&
      (mode_ctrl.clear_source_sel ? status.match_a : status.match_p)
      |=> status.count == COUNT_ZERO;
  endproperty
  a_clear_src: assert property (p_clear_src)
    else $error("counter not cleared by selected match");

  property p_toggle;
    ce && (mode == MODE_COMPARE) && status.match_a && !status.on_rise &&
      (pin_func == CMP_TOGGLE) |=> pin_level != $past(pin_level);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("pin did not toggle on A match");

  property p_init_level;
    ce && (mode == MODE_COMPARE) && status.on_rise
      |=> pin_level == $past(mode_ctrl.pin_initial_level);
  endproperty
  a_init_level: assert property (p_init_level)
    else $error("pin not returned to initial level");

  property p_p_no_pin;
    ce && (mode == MODE_COMPARE) && !status.match_a && !status.on_rise
      |=> pin_level == $past(pin_level);
  endproperty
  a_p_no_pin: assert property (p_p_no_pin)
    else $error("pin changed without A match");

  property p_pwm_full;
    ce && (mode == MODE_PWM) && (pin_func == PWM_WAVE) && (duty >= period)
      |=> timer_out_pin0 == ($past(mode_ctrl.pin_initial_level) ^
                             $past(mode_ctrl.pin_invert));
  endproperty
  a_pwm_full: assert property (p_pwm_full)
    else $error("full duty not held active");

  property p_pins_pair;
    timer_out_pin1 == !timer_out_pin0;
  endproperty
  a_pins_pair: assert property (p_pins_pair)
    else $error("output pins not complementary");

  c_toggle: cover property (ce && status.match_a &&
                            (pin_func == CMP_TOGGLE));
  c_flag_p: cover property (ce && set_p);
  c_pwm_wave: cover property (ce && (mode == MODE_PWM) &&
                              (pin_func == PWM_WAVE) && !wave_active);

endmodule : compact_timer_mode_control
`default_nettype wire

// File: tb/tb_top.sv
`default_nettype none
`define CHK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp); \
  end \
end
module tb_top
  import compact_tm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Clock, reset and bus signals
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic              ce = 1'b1;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0]       wdata = '0, rdata;
  logic              awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic              bready = 1'b0, rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic              pin0, pin1, oe;
  int                failures = 0, comparisons = 0, cycles = 0;
  logic [31:0]       rd_val;
  int                act;

  always #25 aclk = ~aclk;

  compact_timer_mode_control i_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .timer_out_pin0(pin0), .timer_out_pin1(pin1), .timer_out_oe(oe));

  // ==========================================================
  // Closing report, reached from the sequence or the watchdog
  task automatic end_of_test();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  // Watchdog sized well above the longest expected run
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      end_of_test();
    end
  end

  // Bus write: both channels offered at once, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] exp_resp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK(bresp, exp_resp)
  endtask : wr

  // Bus read: response captured at the handshake edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    input logic [1:0] exp_resp);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    `CHK(rresp, exp_resp)
  endtask : rd

  // Stop, clear flags, program and restart; counter stopped while
  // the mode changes so that reconfiguration stays well defined
  task automatic setup(input logic [7:0] mode, input logic [9:0] cmpa,
                       input logic [2:0] cmpp);
    wr(OFS_TIMER_CTRL, 32'h0, RESP_OKAY);
    wr(OFS_FLAGS, 32'h3, RESP_OKAY);
    wr(OFS_COMPARE_A, {22'h0, cmpa}, RESP_OKAY);
    wr(OFS_MODE_CTRL, {24'h0, mode}, RESP_OKAY);
    wr(OFS_TIMER_CTRL, {28'h0, 1'b1, cmpp}, RESP_OKAY);
  endtask : setup

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // ==========================================================
  // Main sequence
  initial begin : main
    logic [1:0] fn;
    logic       ini;
    logic       inv;
    logic       lvl;
    logic [9:0] held;
    cyc(3);
    `CHK({pin0, pin1, oe}, 3'b010)
    aresetn <= 1'b1;
    cyc(2);
    // Compare mode is the reset mode, so the pins are driven at once
    `CHK({pin0, pin1, oe}, 3'b011)
    rd(OFS_MODE_CTRL, rd_val, RESP_OKAY);
    `CHK(rd_val, 32'h0)
    rd(8'h20, rd_val, RESP_SLVERR);
    wr(8'h24, 32'h1, RESP_SLVERR);
    // Compare mode, clear on A at 200, every pin code, level, invert
    for (int i = 0; i < 16; i++) begin
      fn = i[1:0];
      ini = i[2];
      inv = i[3];
      setup({2'b00, fn, ini, inv, 2'b01}, 10'd200, 3'd1);
      cyc(100);
      `CHK(pin0, ini ^ inv)
      `CHK({pin1, oe}, {~(ini ^ inv), 1'b1})
      cyc(200);
      lvl = (fn == CMP_LOW) ? 1'b0 : (fn == CMP_HIGH) ? 1'b1 :
            (fn == CMP_TOGGLE) ? ~ini : ini;
      `CHK(pin0, lvl ^ inv)
      rd(OFS_FLAGS, rd_val, RESP_OKAY);
      `CHK(rd_val[1:0], 2'b01)
      wr(OFS_TIMER_CTRL, 32'h1, RESP_OKAY);
      wr(OFS_TIMER_CTRL, 32'h9, RESP_OKAY);
      cyc(3);
      `CHK(pin0, ini ^ inv)
    end
    // Clear on P at 128, A at 100: both flags in compare and timer mode
    setup({2'b00, 2'b11, 4'b0000}, 10'd100, 3'd1);
    cyc(300);
    rd(OFS_FLAGS, rd_val, RESP_OKAY);
    `CHK(rd_val[1:0], 2'b11)
    setup({2'b11, 2'b00, 4'b0000}, 10'd100, 3'd1);
    cyc(300);
    rd(OFS_FLAGS, rd_val, RESP_OKAY);
    `CHK({rd_val[1:0], oe}, 3'b110)
    // Undefined mode code: counter stands still, pins released
    setup({2'b01, 6'h00}, 10'd10, 3'd1);
    cyc(50);
    rd(OFS_COUNT, rd_val, RESP_OKAY);
    `CHK({rd_val[9:0], oe}, 11'h000)
    // Compare A zero with clear on A: wraps at 3ff, no A flag
    setup({2'b00, 2'b11, 4'b0001}, 10'd0, 3'd1);
    cyc(1100);
    rd(OFS_FLAGS, rd_val, RESP_OKAY);
    `CHK(rd_val[1:0], 2'b00)
    wr(OFS_TIMER_CTRL, 32'h1, RESP_OKAY);
    rd(OFS_COUNT, rd_val, RESP_OKAY);
    held = rd_val[9:0];
    cyc(20);
    rd(OFS_COUNT, rd_val, RESP_OKAY);
    `CHK(rd_val[9:0], held)
    wr(OFS_TIMER_CTRL, 32'h9, RESP_OKAY);
    // Clock enable low freezes the count; a running count would pass 20
    ce <= 1'b0;
    cyc(30);
    ce <= 1'b1;
    rd(OFS_COUNT, rd_val, RESP_OKAY);
    `CHK(rd_val[9:0] < 10'd20, 1'b1)
    // PWM forced levels follow the active level setting
    for (int i = 0; i < 4; i++) begin
      setup({2'b10, 1'b0, i[0], i[1], 3'b000}, 10'd50, 3'd1);
      cyc(5);
      `CHK(pin0, i[0] ~^ i[1])
    end
    // PWM waveform: duty 50 of period 128, then roles swapped
    for (int i = 0; i < 2; i++) begin
      setup({2'b10, 2'b10, 1'b1, 1'b0, i[0], 1'b0}, 10'd50, 3'd1);
      cyc(300);
      act = 0;
      repeat (256) begin
        @(posedge aclk);
        act += (pin0 === 1'b1) ? 1 : 0;
      end
      if (i == 0) begin
        `CHK(act >= 90 && act <= 110, 1'b1)
      end else begin
        `CHK(act, 256)
      end
    end
    end_of_test();
  end : main

endmodule : tb_top
`default_nettype wire
